/* verilog/flash_seq_regs.vh */
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define FS_ADDR_CONTROL      4'h0
`define FS_ADDR_KEY          4'h4
`define FS_ADDR_WIDTH        4
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define FS_BIT_START         15
`define FS_BIT_ENABLE        14
`define FS_BIT_ERROR         13
`define FS_BIT_ERASE         6
`define FS_OPC_HI            3
`define FS_OPC_LO            0
`define FS_CONTROL_RESET     16'h0000
`define FS_CONTROL_RW_MASK   16'h404F
// ------------------------------------------------------------
// key values and operation codes
// ------------------------------------------------------------
`define FS_KEY_FIRST         8'h55
`define FS_KEY_SECOND        8'hAA
`define FS_OPC_ERASE_SEGMENT 4'hD
`define FS_OPC_ERASE_PAGE    4'h2
`define FS_OPC_PROGRAM_WORD  4'h3
// ------------------------------------------------------------
// array geometry and timing
// ------------------------------------------------------------
`define FS_WORD_BITS         24
`define FS_PAGE_INSTR        512
`define FS_ROW_INSTR         64
`define FS_RC_CYCLES_WORD    355
`define FS_RC_FREQ_KHZ       7370
`define FS_CLK_FREQ_KHZ      10000
`define FS_ERASE_TIME_US     20000
`endif

/* verilog/op_timer.v */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// down counter that times one array operation
// ------------------------------------------------------------
module op_timer #(
  parameter WIDTH = 20
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  output wire             busy_o,
  output wire             done_o
);
  reg [WIDTH-1:0] remaining;

  always @(posedge clk_i) begin
    if (rst_i) begin
      remaining <= {WIDTH{1'b0}};
    end else if (load_i) begin
      remaining <= count_i;
    end else if (remaining != {WIDTH{1'b0}}) begin
      remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign busy_o = (remaining != {WIDTH{1'b0}});
  assign done_o = (remaining == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

/* verilog/flash_program_erase_sequencer.v */
// Operation
// [RULE_01] setting start launches the chosen operation; hardware clears start when done
// [RULE_02] start is set by software only, cleared by hardware only, reads busy
// [RULE_03] a program command writes exactly one 24-bit word
// [RULE_04] software erases the containing page before reprogramming a word
// [RULE_05] start is allowed only after key writes 0x55 then 0xAA back to back
// [RULE_06] software follows start with two no-ops and waits out the time
// [RULE_07] erasing the last page also clears configuration words, enabling protection
// [RULE_08] enable bit 1 permits program and erase, 0 inhibits them
// [RULE_09] error flag set on improper attempt or early end; cleared by normal completion
// [RULE_10] erase-select 1 runs the coded erase, 0 the coded program
// [RULE_11] erase codes: 1101 erases general segment, 0010 one page, others nothing
// [RULE_12] program code 0011 writes one word, others do nothing
// [RULE_13] control bits reset only on power-on reset, not other resets
// [RULE_14] unimplemented control bits and key upper byte read zero
// [RULE_15] key register is write-only with an 8-bit key in the low byte
// [RULE_16] word write lasts 355 cycles of the 7.37 MHz internal oscillator
// [RULE_17] processor stalls from operation start until it finishes
// [RULE_18] erase page is 8 rows of 64 instructions, aligned on 1536 bytes
// [RULE_19] unlock cleared by out-of-order key write and after any start set
// [RULE_20] start without enable or unlock runs nothing and raises error
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_regs.vh"
module flash_program_erase_sequencer #(
  parameter ADDR_BITS      = 24,
  parameter PAGE_INSTR     = `FS_PAGE_INSTR,
  parameter ERASE_CYCLES   = (`FS_ERASE_TIME_US * `FS_CLK_FREQ_KHZ) / 1000,
  parameter TIMER_WIDTH    = 20
) (
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  por_i,
  input  wire [3:0]            adr_i,
  input  wire [31:0]           dat_i,
  input  wire [3:0]            sel_i,
  input  wire                  we_i,
  input  wire                  cyc_i,
  input  wire                  stb_i,
  output reg  [31:0]           dat_o,
  output reg                   ack_o,
  output wire                  err_o,
  input  wire [ADDR_BITS-1:0]  target_addr_i,
  input  wire [23:0]           write_word_i,
  input  wire [ADDR_BITS-1:0]  last_page_addr_i,
  output wire                  cpu_stall_o,
  output reg                   array_program_o,
  output reg                   array_erase_page_o,
  output reg                   array_erase_segment_o,
  output reg  [ADDR_BITS-1:0]  array_addr_o,
  output reg  [23:0]           array_data_o,
  output reg                   config_cleared_o,
  input  wire                  abort_i
);
  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  // word time rounded up to whole system clocks
  localparam [31:0] WORD_CYCLES = (`FS_RC_CYCLES_WORD * `FS_CLK_FREQ_KHZ + `FS_RC_FREQ_KHZ - 1)
                                  / `FS_RC_FREQ_KHZ;
  localparam [31:0] ERASE_CYCLES_ALL = ERASE_CYCLES;
  localparam [TIMER_WIDTH-1:0] WORD_COUNT  = WORD_CYCLES[TIMER_WIDTH-1:0];
  localparam [TIMER_WIDTH-1:0] ERASE_COUNT = ERASE_CYCLES_ALL[TIMER_WIDTH-1:0];
  localparam [31:0] PAGE_MASK_ALL = ~((PAGE_INSTR * 2) - 1);

  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_DONE = 2'b10;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg                   start;
  reg                   enable;
  reg                   error;
  reg                   erase_sel;
  reg  [3:0]            opcode;
  reg  [1:0]            unlock;
  reg  [1:0]            state;
  reg                   timer_load;
  reg  [TIMER_WIDTH-1:0] timer_count;
  wire                  timer_busy;
  wire                  timer_done;

  wire bus_req   = cyc_i & stb_i & ~ack_o;
  wire hit_ctrl  = (adr_i == `FS_ADDR_CONTROL);
  wire hit_key   = (adr_i == `FS_ADDR_KEY);
  wire wr_ctrl   = bus_req & we_i & hit_ctrl & sel_i[1];
  wire wr_ctrl_lo = bus_req & we_i & hit_ctrl & sel_i[0];
  wire wr_key    = bus_req & we_i & hit_key & sel_i[0];
  wire start_req = wr_ctrl & dat_i[`FS_BIT_START] & ~start;
  wire unlocked  = (unlock == 2'b10);

  // decode of a code into one of the three array operations, or none for any other code
  function [2:0] decode_op;
    input       erase_f;
    input [3:0] code_f;
    begin
      decode_op = 3'b000;
      if (erase_f && code_f == `FS_OPC_ERASE_SEGMENT) begin
        decode_op = 3'b100;                                     // see [RULE_11]
      end else if (erase_f && code_f == `FS_OPC_ERASE_PAGE) begin
        decode_op = 3'b010;                                     // see [RULE_11]
      end else if (!erase_f && code_f == `FS_OPC_PROGRAM_WORD) begin
        decode_op = 3'b001;                                     // see [RULE_12]
      end
    end
  endfunction

  // the control in force at the start write, including a same-write mode change
  wire       eff_erase  = wr_ctrl_lo ? dat_i[`FS_BIT_ERASE] : erase_sel;
  wire [3:0] eff_opcode = wr_ctrl_lo ? dat_i[`FS_OPC_HI:`FS_OPC_LO] : opcode;
  wire       eff_enable = dat_i[`FS_BIT_ENABLE];
  wire [2:0] op_sel     = decode_op(eff_erase, eff_opcode);    // see [RULE_10]
  wire       legal      = eff_enable & unlocked;                // see [RULE_08] [RULE_20]

  // page base: pages of 512 instructions, aligned from address zero
  wire [ADDR_BITS-1:0] page_mask = PAGE_MASK_ALL[ADDR_BITS-1:0]; // see [RULE_18]
  wire [ADDR_BITS-1:0] page_base = target_addr_i & page_mask;

  // ------------------------------------------------------------
  // timer
  // ------------------------------------------------------------
  op_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_timer (
    .clk_i   (clk_i),
    // a warm reset must not cut a running operation short, so only por_i clears the timer
    .rst_i   (por_i),
    .load_i  (timer_load),
    .count_i (timer_count),
    .busy_o  (timer_busy),
    .done_o  (timer_done)
  );

  // ------------------------------------------------------------
  // unlock tracking
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (por_i) begin
      unlock <= 2'b00;
    end else if (start_req) begin
      unlock <= 2'b00;                                          // see [RULE_19]
    end else if (wr_key) begin
      if (dat_i[7:0] == `FS_KEY_FIRST) begin                    // see [RULE_05] [RULE_15]
        unlock <= 2'b01;
      end else if (unlock == 2'b01 && dat_i[7:0] == `FS_KEY_SECOND) begin
        unlock <= 2'b10;
      end else begin
        unlock <= 2'b00;                                        // see [RULE_19]
      end
    end else if (bus_req && we_i && unlock == 2'b01) begin
      unlock <= 2'b00;                                          // any other write breaks order
    end
  end

  // ------------------------------------------------------------
  // control register and sequencer
  // ------------------------------------------------------------
  // only por_i clears these; rst_i is a warm reset and leaves them alone
  always @(posedge clk_i) begin
    if (por_i) begin                                            // see [RULE_13]
      start                 <= 1'b0;
      enable                <= 1'b0;
      error                 <= 1'b0;
      erase_sel             <= 1'b0;
      opcode                <= 4'h0;
      state                 <= ST_IDLE;
      timer_load            <= 1'b0;
      timer_count           <= {TIMER_WIDTH{1'b0}};
      array_program_o       <= 1'b0;
      array_erase_page_o    <= 1'b0;
      array_erase_segment_o <= 1'b0;
      array_addr_o          <= {ADDR_BITS{1'b0}};
      array_data_o          <= 24'h000000;
      config_cleared_o      <= 1'b0;
    end else begin
      timer_load       <= 1'b0;
      config_cleared_o <= 1'b0;
      if (wr_ctrl) begin
        enable <= dat_i[`FS_BIT_ENABLE];
        if (!start) begin
          error <= dat_i[`FS_BIT_ERROR];
        end
      end
      if (wr_ctrl_lo && !start) begin
        erase_sel <= dat_i[`FS_BIT_ERASE];
        opcode    <= dat_i[`FS_OPC_HI:`FS_OPC_LO];
      end
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            if (!legal) begin
              error <= 1'b1;                                    // see [RULE_09] [RULE_20]
            end else begin
              start <= 1'b1;                                    // see [RULE_01] [RULE_02]
              error <= 1'b0;
              state <= ST_RUN;
              timer_load <= 1'b1;
              array_program_o       <= op_sel[0];
              array_erase_page_o    <= op_sel[1];
              array_erase_segment_o <= op_sel[2];
              array_addr_o <= op_sel[1] ? page_base : target_addr_i;
              array_data_o <= write_word_i;                     // see [RULE_03]
              timer_count  <= op_sel[0] ? WORD_COUNT : ERASE_COUNT; // see [RULE_16]
              // a no-operation code still runs the timer, but touches nothing
              if (op_sel[1] && page_base == (last_page_addr_i & page_mask)) begin
                config_cleared_o <= 1'b1;                       // see [RULE_07]
              end
            end
          end
        end
        ST_RUN: begin
          if (abort_i) begin
            error <= 1'b1;                                      // see [RULE_09]
            state <= ST_DONE;
          end else if (timer_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          start                 <= 1'b0;                        // see [RULE_01] [RULE_02]
          array_program_o       <= 1'b0;
          array_erase_page_o    <= 1'b0;
          array_erase_segment_o <= 1'b0;
          state                 <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // stall covers the start write itself so the cpu never runs past it
  assign cpu_stall_o = start | (start_req & legal);             // see [RULE_17]

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  assign err_o = 1'b0;

  always @(posedge clk_i) begin
    if (rst_i | por_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h00000000;
      if (bus_req && !we_i && hit_ctrl) begin
        dat_o[`FS_BIT_START]  <= start;                         // see [RULE_14]
        dat_o[`FS_BIT_ENABLE] <= enable;
        dat_o[`FS_BIT_ERROR]  <= error;
        dat_o[`FS_BIT_ERASE]  <= erase_sel;
        dat_o[`FS_OPC_HI:`FS_OPC_LO] <= opcode;
      end
      // key reads and unmapped reads return zero
    end
  end
endmodule
`default_nettype wire

/* tb/flash_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module flash_seq_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        por_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        abort_i,
  input wire logic        cpu_stall_o,
  input wire logic        array_program_o,
  input wire logic        array_erase_page_o,
  input wire logic        array_erase_segment_o,
  input wire logic        config_cleared_o,
  input wire logic [23:0] array_data_o,
  input wire logic [23:0] write_word_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (por_i || rst_i);
  wire        op = array_program_o | array_erase_page_o | array_erase_segment_o;
  logic [9:0] len = 10'h000;
  // counted here since a repetition of ~480 would be far too slow to unroll
  always @(posedge clk_i) len <= array_program_o ? len + 10'h001 : 10'h000;
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  sequence s_pulse; ack_o ##1 !ack_o; endsequence
  a_ack_timing: assert property (s_take |=> s_pulse) else $error("ack late or long");
  a_err_quiet: assert property (!err_o) else $error("bus error raised");
  a_one_op: assert property ($onehot0({array_program_o, array_erase_page_o,
    array_erase_segment_o})) else $error("two array operations at once");
  a_stall_hold: assert property (op |-> cpu_stall_o) else $error("no stall");
  a_word_time: assert property ($fell(array_program_o) |->
    len > 10'h1DD && len < 10'h1E9) else $error("word write length wrong");
  a_word_data: assert property ($rose(array_program_o) |->
    array_data_o == write_word_i) else $error("word data wrong");
  a_cfg_pulse: assert property (config_cleared_o |=>
    !config_cleared_o && array_erase_page_o) else $error("config clear pulse wrong");
  a_abort_stop: assert property (abort_i && op |-> ##[1:3] !op)
    else $error("abort ignored");
  a_por_idle: assert property ($fell(por_i) |-> !op && !cpu_stall_o)
    else $error("busy after power-on reset");
endmodule
`default_nettype wire

/* tb/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// program memory array: counts each operation as it starts
// ----
module flash_array_model (
  input wire logic        clk_i,
  input wire logic        program_i,
  input wire logic        erase_page_i,
  input wire logic        erase_segment_i,
  input wire logic        config_cleared_i,
  input wire logic [23:0] addr_i,
  input wire logic [23:0] data_i
);
  int          n_prog = 0;
  int          n_page = 0;
  int          n_seg  = 0;
  int          n_cfg  = 0;
  logic [23:0] last_addr = 24'h000000;
  logic [23:0] last_data = 24'h000000;
  logic [2:0]  q = 3'h0;
  always @(posedge clk_i) begin
    q <= {program_i, erase_page_i, erase_segment_i};
    if (program_i && !q[2]) begin
      n_prog++;
      last_addr <= addr_i;
      last_data <= data_i;
    end
    if (erase_page_i && !q[1]) begin
      n_page++;
      last_addr <= addr_i;
    end
    if (erase_segment_i && !q[0]) n_seg++;
    if (config_cleared_i) n_cfg++;
  end
endmodule
`default_nettype wire

/* tb/flash_program_erase_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module flash_program_erase_sequencer_test;
  localparam [3:0] CTL = 4'h0, KEY = 4'h4, BAD = 4'h8;
  logic clk_i = 0, rst_i = 1, por_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, abort_i = 0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, q;
  logic [23:0] target_addr_i = 24'h000400, write_word_i = 24'hA5C3E1;
  logic [23:0] last_page_addr_i = 24'h007C00;
  wire  [31:0] dat_o;
  wire  [23:0] aa, ad;
  wire         ack_o, err_o, cpu_stall_o, ap, ep, es, cc;
  int miscompares = 0, samples_checked = 0;
  always #50 clk_i = ~clk_i;
  flash_program_erase_sequencer #(.ERASE_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .por_i(por_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .target_addr_i(target_addr_i),
    .write_word_i(write_word_i), .last_page_addr_i(last_page_addr_i), .cpu_stall_o(cpu_stall_o),
    .array_program_o(ap), .array_erase_page_o(ep), .array_erase_segment_o(es),
    .array_addr_o(aa), .array_data_o(ad), .config_cleared_o(cc), .abort_i(abort_i));
  flash_array_model model_u (.clk_i(clk_i), .program_i(ap), .erase_page_i(ep),
    .erase_segment_i(es), .config_cleared_i(cc), .addr_i(aa), .data_i(ad));
  task wb(input [3:0] a, input w, input [15:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, adr_i, we_i, dat_i} <= {2'h3, a, w, 16'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (ack_o !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t no bus acknowledge", $time);
    end
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task unlock; wb(KEY, 1, 16'h0055); wb(KEY, 1, 16'h00AA); endtask
  task wait_idle;
    int n;
    n = 0;
    do begin wb(CTL, 0, 16'h0); n++; end while (q[15] !== 1'b0 && n < 400);
    if (q[15] !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t start never cleared", $time);
    end
  endtask
  // two idle cycles after start stand in for the two no-ops
  task run(input [15:0] c); unlock(); wb(CTL, 1, c); repeat (2) @(posedge clk_i); wait_idle(); endtask
  task refused(input [15:0] c);
    wb(CTL, 1, c);
    wb(CTL, 0, 16'h0);
    chk(q & 32'hA000, 32'h2000);
    wb(CTL, 1, 16'h0);
  endtask
  task t_regs;
    wb(CTL, 0, 16'h0); chk(q, 32'h0);
    wb(KEY, 0, 16'h0); chk(q, 32'h0);
    wb(BAD, 0, 16'h0); chk(q, 32'h0);
    wb(CTL, 1, 16'h7FFF); wb(CTL, 0, 16'h0); chk(q, 32'h604F);
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(CTL, 0, 16'h0); chk(q, 32'h604F);
    @(posedge clk_i) por_i <= 1;
    repeat (2) @(posedge clk_i);
    por_i <= 0;
    wb(CTL, 0, 16'h0); chk(q, 32'h0);
    $display("regs test done");
  endtask
  task t_program;
    run(16'hC042); chk(model_u.n_page, 1);
    unlock();
    wb(CTL, 1, 16'hC003);
    repeat (2) @(posedge clk_i);
    wb(CTL, 0, 16'h0); chk(q[15], 1);
    // a warm reset in mid-write must leave the operation running
    @(posedge clk_i) rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(CTL, 0, 16'h0); chk(q[15], 1);
    wait_idle(); chk(q, 32'h4003);
    chk(model_u.n_prog, 1);
    chk(model_u.last_data, write_word_i);
    chk(model_u.last_addr, target_addr_i);
    $display("program test done");
  endtask
  task t_codes;
    logic [7:0] c [10];
    c = '{8'h42, 8'h4D, 8'h4F, 8'h4C, 8'h43, 8'h41, 8'h40, 8'h03, 8'h02, 8'h0D};
    for (int i = 0; i < 10; i++) begin
      run({8'hC0, c[i]}); chk(q[13], 0);
    end
    chk(model_u.n_page, 2);
    chk(model_u.n_seg, 1);
    chk(model_u.n_prog, 2);
    $display("codes test done");
  endtask
  task t_refuse;
    refused(16'hC003);
    wb(KEY, 1, 16'h0055); wb(KEY, 1, 16'h0000); wb(KEY, 1, 16'h00AA);
    refused(16'hC003);
    unlock(); refused(16'h8003);
    refused(16'hC003);
    chk(model_u.n_prog, 2);
    $display("refuse test done");
  endtask
  task t_abort;
    unlock();
    wb(CTL, 1, 16'hC042);
    @(posedge clk_i) abort_i <= 1;
    repeat (2) @(posedge clk_i);
    abort_i <= 0;
    wait_idle(); chk(q[13], 1);
    wb(CTL, 1, 16'h0);
    target_addr_i <= last_page_addr_i + 24'h000123;
    run(16'hC042); chk(model_u.n_cfg, 1);
    chk(model_u.last_addr, 24'h007C00);
    $display("abort and last page test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    {por_i, rst_i} <= 2'h0;
    t_regs(); t_program(); t_codes(); t_refuse(); t_abort();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
endmodule
bind flash_program_erase_sequencer flash_seq_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .abort_i(abort_i),
  .cpu_stall_o(cpu_stall_o), .array_program_o(array_program_o),
  .array_erase_page_o(array_erase_page_o), .array_erase_segment_o(array_erase_segment_o),
  .config_cleared_o(config_cleared_o), .array_data_o(array_data_o),
  .write_word_i(write_word_i));
`default_nettype wire
